// ### design/dbgc_cause_enc.sv
`timescale 1ns/100ps
`include "dbgc_cfg.svh"
module dbgc_cause_enc (
    // Requests in, chosen cause out
    dbgc_cause_if.enc bus
);
    import dbgc_pkg::*;

    // Fixed priority: trigger, ebreak, reset halt, group, haltreq, step,
    // other. Exactly one code results however many requests coincide.
    function automatic dbgc_cause_type pick(input dbgc_req_type r);
        dbgc_cause_type c;
        c = DBGC_CAUSE_NONE;
        if (r.trigger) begin
            c = DBGC_CAUSE_TRIGGER;
        end else if (r.ebreak) begin
            c = DBGC_CAUSE_EBREAK;
        end else if (r.resethalt) begin
            c = (`DBGC_RESET_AS_HALTREQ == 1'h1) ? DBGC_CAUSE_HALTREQ
                                                  : DBGC_CAUSE_RESETHALT;
        end else if (r.group) begin
            c = (`DBGC_GROUP_AS_HALTREQ == 1'h1) ? DBGC_CAUSE_HALTREQ
                                                  : DBGC_CAUSE_GROUP;
        end else if (r.haltreq) begin
            c = DBGC_CAUSE_HALTREQ;
        end else if (r.step) begin
            c = DBGC_CAUSE_STEP;
        end else if (r.other) begin
            c = DBGC_CAUSE_OTHER;
        end
        return c;
    endfunction

    always_comb begin
        bus.code = pick(bus.req);
        bus.hit = |bus.req;
    end
endmodule

// ### design/dbgc_cause_if.sv
`timescale 1ns/100ps
interface dbgc_cause_if;
    import dbgc_pkg::*;

    dbgc_req_type req;
    logic hit;
    dbgc_cause_type code;

    modport src (output req, input hit, input code);
    modport enc (input req, output hit, output code);
endinterface

// ### design/dbgc_cfg.svh
`ifndef DBGC_CFG_SVH
`define DBGC_CFG_SVH

// Register byte offsets on the APB port
`define DBGC_OFS_CSR 8'h00
`define DBGC_OFS_IRQ_STAT 8'h04
`define DBGC_OFS_IRQ_MASK 8'h08
`define DBGC_OFS_HART_STAT 8'h0C

// Field positions in the debug control/status word
`define DBGC_PRV_LSB 0
`define DBGC_PRV_MSB 1
`define DBGC_STEP_BIT 2
`define DBGC_NMIP_BIT 3
`define DBGC_MPRVEN_BIT 4
`define DBGC_V_BIT 5
`define DBGC_CAUSE_LSB 6
`define DBGC_CAUSE_MSB 8

// Field positions in the interrupt status and mask words
`define DBGC_IRQ_ENTRY_BIT 0
`define DBGC_IRQ_NMI_BIT 1
`define DBGC_IRQ_W 2

// Reset values
`define DBGC_PRV_RST 2'h3
`define DBGC_MPRVEN_RST 1'h1
`define DBGC_MASK_RST 2'h0

// Hart capabilities
`define DBGC_HAS_VIRT 1'h1
`define DBGC_HAS_SMODE 1'h1
`define DBGC_HAS_UMODE 1'h1
`define DBGC_MPRVEN_WRITABLE 1'h1

// Allowed alternative cause reports
`define DBGC_RESET_AS_HALTREQ 1'h0
`define DBGC_GROUP_AS_HALTREQ 1'h0

`endif

// ### design/dbgc_csr.sv
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "dbgc_cfg.svh"
module dbgc_csr (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Hart side, same clock
    input wire dbgc_pkg::dbgc_req_type hart_req,
    input wire logic hart_retire,
    input wire logic hart_resume,
    input wire logic [1:0] hart_priv,
    input wire logic hart_virt,
    input wire logic hart_mprv,
    input wire logic hart_nmi,
    // Debug state towards the hart
    output logic in_debug,
    output logic [1:0] resume_priv,
    output logic resume_virt,
    output logic step_en,
    output logic mprv_effective,
    // Interrupt
    output logic irq
);
    import dbgc_pkg::*;

    // Falls back to machine mode for anything the hart cannot run in
    function automatic logic [1:0] legal_priv(input logic [1:0] p);
        logic [1:0] r;
        r = DBGC_PRV_MACHINE;
        case (p)
            DBGC_PRV_USER: r = (`DBGC_HAS_UMODE == 1'h1) ? p
                                                          : DBGC_PRV_MACHINE;
            DBGC_PRV_SUPER: r = (`DBGC_HAS_SMODE == 1'h1) ? p
                                                           : DBGC_PRV_MACHINE;
            default: r = DBGC_PRV_MACHINE;
        endcase
        return r;
    endfunction

    // Virtual mode only exists below machine mode
    function automatic logic legal_virt(input logic v, input logic [1:0] p);
        return v & `DBGC_HAS_VIRT & (legal_priv(p) != DBGC_PRV_MACHINE);
    endfunction

    dbgc_cause_if cause_bus ();

    dbgc_cause_enc u_enc (
        .bus(cause_bus)
    );

    logic in_debug_q;
    logic [2:0] cause_q;
    logic [1:0] prv_q;
    logic v_q;
    logic step_q;
    logic mprven_q;
    logic nmip_q;
    logic mprv_eff_q;
    logic [`DBGC_IRQ_W-1:0] irq_stat_q;
    logic [`DBGC_IRQ_W-1:0] irq_stat_d;
    logic [`DBGC_IRQ_W-1:0] irq_mask_q;
    logic irq_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic step_hit;
    logic enter;
    logic setup;
    logic wr_en;
    logic mapped;
    logic [31:0] csr_word;

    // Step ends after exactly one retired instruction outside debug mode
    assign step_hit = step_q & ~in_debug_q & hart_retire;

    always_comb begin
        cause_bus.req = hart_req;
        cause_bus.req.step = hart_req.step | step_hit;
    end

    assign enter = cause_bus.hit & ~in_debug_q;

    // APB decode; a zero-wait answer follows every setup cycle
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & pready_q;
    assign mapped = (paddr == `DBGC_OFS_CSR) ||
                    (paddr == `DBGC_OFS_IRQ_STAT) ||
                    (paddr == `DBGC_OFS_IRQ_MASK) ||
                    (paddr == `DBGC_OFS_HART_STAT);

    always_comb begin
        csr_word = 32'h0;
        csr_word[`DBGC_PRV_MSB:`DBGC_PRV_LSB] = prv_q;
        csr_word[`DBGC_STEP_BIT] = step_q;
        csr_word[`DBGC_NMIP_BIT] = nmip_q;
        csr_word[`DBGC_MPRVEN_BIT] = mprven_q;
        csr_word[`DBGC_V_BIT] = v_q;
        csr_word[`DBGC_CAUSE_MSB:`DBGC_CAUSE_LSB] = cause_q;
    end

    // Debug mode tracking; leave only on the hart's resume pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_debug_q <= 1'h0;
        end else if (enter) begin
            in_debug_q <= 1'h1;
        end else if (hart_resume) begin
            in_debug_q <= 1'h0;
        end
    end

    // Cause has no write path at all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_q <= 3'h0;
        end else if (enter) begin
            cause_q <= cause_bus.code;
        end
    end

    // Entry capture beats a debugger write landing in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prv_q <= `DBGC_PRV_RST;
            v_q <= 1'h0;
        end else if (enter) begin
            prv_q <= legal_priv(hart_priv);
            v_q <= legal_virt(hart_virt, hart_priv);
        end else if (wr_en && paddr == `DBGC_OFS_CSR) begin
            prv_q <= legal_priv(pwdata[`DBGC_PRV_MSB:`DBGC_PRV_LSB]);
            v_q <= legal_virt(pwdata[`DBGC_V_BIT],
                              pwdata[`DBGC_PRV_MSB:`DBGC_PRV_LSB]);
        end
    end

    // Writes while running are dropped as a guard against a bad debugger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_q <= 1'h0;
        end else if (wr_en && paddr == `DBGC_OFS_CSR && in_debug_q) begin
            step_q <= pwdata[`DBGC_STEP_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mprven_q <= `DBGC_MPRVEN_RST;
        end else if (wr_en && paddr == `DBGC_OFS_CSR &&
                     `DBGC_MPRVEN_WRITABLE == 1'h1) begin
            mprven_q <= pwdata[`DBGC_MPRVEN_BIT];
        end
    end

    // Outside debug mode mprv passes through untouched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mprv_eff_q <= 1'h0;
        end else begin
            mprv_eff_q <= in_debug_q ? (mprven_q & hart_mprv)
                                     : hart_mprv;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmip_q <= 1'h0;
        end else begin
            nmip_q <= hart_nmi;
        end
    end

    // Sticky events; a new event wins over a write-one-to-clear
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_en && paddr == `DBGC_OFS_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~pwdata[`DBGC_IRQ_W-1:0];
        end
        if (enter) begin
            irq_stat_d[`DBGC_IRQ_ENTRY_BIT] = 1'h1;
        end
        if (hart_nmi && !nmip_q) begin
            irq_stat_d[`DBGC_IRQ_NMI_BIT] = 1'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= `DBGC_MASK_RST;
        end else if (wr_en && paddr == `DBGC_OFS_IRQ_MASK) begin
            irq_mask_q <= pwdata[`DBGC_IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'h0;
        end else begin
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    // Read data is latched at the setup edge, valid in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'h0;
            pslverr_q <= 1'h0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup && !pwrite) begin
                case (paddr)
                    `DBGC_OFS_CSR: prdata_q <= csr_word;
                    `DBGC_OFS_IRQ_STAT: prdata_q <= {30'h0, irq_stat_q};
                    `DBGC_OFS_IRQ_MASK: prdata_q <= {30'h0, irq_mask_q};
                    `DBGC_OFS_HART_STAT: prdata_q <= {28'h0, in_debug_q,
                                                      hart_virt, hart_priv};
                    default: prdata_q <= 32'h0;
                endcase
            end else if (setup) begin
                prdata_q <= 32'h0;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign in_debug = in_debug_q;
    assign resume_priv = prv_q;
    assign resume_virt = v_q;
    assign step_en = step_q;
    assign mprv_effective = mprv_eff_q;
    assign irq = irq_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_prio;
        enter && cause_bus.req.trigger |=> cause_q == DBGC_CAUSE_TRIGGER;
    endproperty
    a_prio: assert property (p_prio) else $error("trigger lost");

    property p_ebreak;
        enter && cause_bus.req == 7'h20 |=> cause_q == DBGC_CAUSE_EBREAK;
    endproperty
    a_ebreak: assert property (p_ebreak) else $error("bad ebreak");

    property p_resethalt;
        enter && cause_bus.req == 7'h10 |=>
            cause_q == DBGC_CAUSE_RESETHALT || cause_q == DBGC_CAUSE_HALTREQ;
    endproperty
    a_resethalt: assert property (p_resethalt) else $error("bad reset");

    property p_group;
        enter && cause_bus.req == 7'h08 |=>
            cause_q == DBGC_CAUSE_GROUP || cause_q == DBGC_CAUSE_HALTREQ;
    endproperty
    a_group: assert property (p_group) else $error("bad group");

    property p_other;
        enter && cause_bus.req == 7'h01 |=> cause_q == DBGC_CAUSE_OTHER;
    endproperty
    a_other: assert property (p_other) else $error("bad other");

    property p_cause_ro;
        wr_en && !enter |=> $stable(cause_q);
    endproperty
    a_cause_ro: assert property (p_cause_ro) else $error("cause written");

    property p_virt_capture;
        enter |=> v_q == ($past(hart_virt) & `DBGC_HAS_VIRT &
                          (prv_q != DBGC_PRV_MACHINE));
    endproperty
    a_virt_capture: assert property (p_virt_capture) else $error("bad v");

    property p_virt_tied;
        `DBGC_HAS_VIRT == 1'h0 |-> !v_q;
    endproperty
    a_virt_tied: assert property (p_virt_tied) else $error("v not zero");

    property p_mprv_ignored;
        in_debug_q && !mprven_q ##1 in_debug_q |-> !mprv_eff_q;
    endproperty
    a_mprv_ignored: assert property (p_mprv_ignored) else $error("mprv used");

    property p_nmip;
        hart_nmi [*2] |-> nmip_q;
    endproperty
    a_nmip: assert property (p_nmip) else $error("nmip missed");

    property p_step;
        step_hit && hart_req == 7'h00 |=>
            in_debug_q && cause_q == DBGC_CAUSE_STEP;
    endproperty
    a_step: assert property (p_step) else $error("step failed");

    property p_prv_capture;
        enter && hart_priv != DBGC_PRV_RSVD |=> prv_q == $past(hart_priv);
    endproperty
    a_prv_capture: assert property (p_prv_capture) else $error("bad prv");

    property p_prv_write;
        wr_en && !enter && paddr == `DBGC_OFS_CSR &&
            pwdata[1:0] == DBGC_PRV_SUPER |=> prv_q == DBGC_PRV_SUPER;
    endproperty
    a_prv_write: assert property (p_prv_write) else $error("prv write");

    property p_prv_legal;
        prv_q != DBGC_PRV_RSVD;
    endproperty
    a_prv_legal: assert property (p_prv_legal) else $error("prv illegal");

    property p_hold;
        in_debug_q && !hart_resume |=> $stable(cause_q) && in_debug_q;
    endproperty
    a_hold: assert property (p_hold) else $error("fields moved");

    property p_irq;
        irq_stat_q[`DBGC_IRQ_ENTRY_BIT] && irq_mask_q[`DBGC_IRQ_ENTRY_BIT]
            ##1 irq_stat_q[`DBGC_IRQ_ENTRY_BIT] |-> irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    c_step: cover property (step_hit ##1 in_debug_q);
    c_multi: cover property (enter && cause_bus.req.ebreak &&
                             cause_bus.req.haltreq);
    c_write: cover property (wr_en && paddr == `DBGC_OFS_CSR);
    c_resume: cover property (in_debug_q && hart_resume);
endmodule

// ### design/dbgc_pkg.sv
package dbgc_pkg;

    typedef enum logic [2:0] {
        DBGC_CAUSE_NONE = 3'h0,
        DBGC_CAUSE_EBREAK = 3'h1,
        DBGC_CAUSE_TRIGGER = 3'h2,
        DBGC_CAUSE_HALTREQ = 3'h3,
        DBGC_CAUSE_STEP = 3'h4,
        DBGC_CAUSE_RESETHALT = 3'h5,
        DBGC_CAUSE_GROUP = 3'h6,
        DBGC_CAUSE_OTHER = 3'h7
    } dbgc_cause_type;

    typedef enum logic [1:0] {
        DBGC_PRV_USER = 2'h0,
        DBGC_PRV_SUPER = 2'h1,
        DBGC_PRV_RSVD = 2'h2,
        DBGC_PRV_MACHINE = 2'h3
    } dbgc_prv_type;

    // Reasons to enter debug mode, one bit each, raised by hart logic
    typedef struct packed {
        logic trigger;
        logic ebreak;
        logic resethalt;
        logic group;
        logic haltreq;
        logic step;
        logic other;
    } dbgc_req_type;

endpackage

// ### tb/dbgc_hart_model.sv
`timescale 1ns/100ps
module dbgc_hart_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Debugger side: request to let the hart run
    input wire logic kick,
    // Debug state from the block
    input wire logic in_debug,
    input wire logic step_en,
    // Hart run control towards the block
    output logic hart_resume,
    output logic hart_retire
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hart_resume <= 1'h0;
            hart_retire <= 1'h0;
        end else begin
            // Resume only makes sense while halted
            hart_resume <= kick & in_debug;
            // A stepping hart retires exactly one instruction
            hart_retire <= hart_resume & step_en;
        end
    end
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
`include "dbgc_cfg.svh"
module tb;
    import dbgc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    dbgc_req_type hart_req;
    logic hart_retire, hart_resume, hart_virt, hart_mprv, hart_nmi, kick;
    logic [1:0] hart_priv, resume_priv;
    logic in_debug, resume_virt, step_en, mprv_effective, irq;
    int errors, n_tests;
    dbgc_csr dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hart_req(hart_req), .hart_retire(hart_retire),
        .hart_resume(hart_resume), .hart_priv(hart_priv),
        .hart_virt(hart_virt), .hart_mprv(hart_mprv), .hart_nmi(hart_nmi),
        .in_debug(in_debug), .resume_priv(resume_priv),
        .resume_virt(resume_virt), .step_en(step_en),
        .mprv_effective(mprv_effective), .irq(irq));
    dbgc_hart_model hart_u (.pclk(pclk), .presetn(presetn), .kick(kick),
        .in_debug(in_debug), .step_en(step_en), .hart_resume(hart_resume),
        .hart_retire(hart_retire));
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    task conclude;
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    // Read data and error land in rd and err
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) begin
            errors++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Let the write land before the caller looks at the outputs
        @(posedge pclk);
    endtask
    task enter(input dbgc_req_type r);
        @(posedge pclk);
        hart_req <= r;
        @(posedge pclk);
        hart_req <= '0;
        @(posedge pclk);
    endtask
    task resume;
        @(posedge pclk);
        kick <= 1'h1;
        @(posedge pclk);
        kick <= 1'h0;
        repeat (3) @(posedge pclk);
    endtask
    task t_reset;
        chk("in_debug", 32'(in_debug), 32'h0);
        chk("step_en", 32'(step_en), 32'h0);
        apb(1'h0, `DBGC_OFS_CSR, 32'h0);
        chk("csr reset", rd, 32'h00000013);
        apb(1'h0, `DBGC_OFS_IRQ_MASK, 32'h0);
        chk("mask reset", rd, 32'h0);
        apb(1'h1, 8'h10, 32'hFFFFFFFF);
        chk("unmapped err", 32'(err), 32'h1);
        apb(1'h0, 8'h10, 32'h0);
        chk("unmapped data", rd, 32'h0);
    endtask
    task t_prio;
        dbgc_cause_type exp_c [7];
        exp_c = '{DBGC_CAUSE_TRIGGER, DBGC_CAUSE_EBREAK, DBGC_CAUSE_RESETHALT,
            DBGC_CAUSE_GROUP, DBGC_CAUSE_HALTREQ, DBGC_CAUSE_STEP,
            DBGC_CAUSE_OTHER};
        for (int i = 0; i < 7; i++) begin
            hart_priv <= i[0] ? DBGC_PRV_SUPER : DBGC_PRV_USER;
            hart_virt <= i[0];
            // Every lower-priority reason is raised with the chosen one
            enter(dbgc_req_type'(7'(7'h7F >> i)));
            chk("in_debug", 32'(in_debug), 32'h1);
            apb(1'h0, `DBGC_OFS_CSR, 32'h0);
            chk("cause", 32'(rd[8:6]), 32'(exp_c[i]));
            chk("prv", 32'(rd[1:0]), 32'(i[0]));
            chk("v", 32'(rd[5]), 32'(i[0]));
            // A new reason while halted must not disturb the capture
            hart_priv <= DBGC_PRV_MACHINE;
            enter(dbgc_req_type'(7'h40));
            apb(1'h0, `DBGC_OFS_CSR, 32'h0);
            chk("held fields", 32'(rd[8:0] & 9'h1E3),
                32'({exp_c[i], i[0], 3'h0, 1'h0, i[0]}));
            resume;
            chk("in_debug", 32'(in_debug), 32'h0);
        end
    endtask
    task t_modes;
        enter(dbgc_req_type'(7'h04));
        apb(1'h0, `DBGC_OFS_HART_STAT, 32'h0);
        chk("hart stat", rd, 32'h0000000B);
        apb(1'h1, `DBGC_OFS_CSR, 32'h000001F0);
        apb(1'h0, `DBGC_OFS_CSR, 32'h0);
        chk("cause ro", 32'(rd[8:6]), 32'h3);
        chk("vu mode", 32'(rd[5:0] & 6'h23), 32'h20);
        chk("resume_priv", 32'(resume_priv), 32'h0);
        chk("resume_virt", 32'(resume_virt), 32'h1);
        apb(1'h1, `DBGC_OFS_CSR, 32'h00000022);
        chk("legal priv", 32'(resume_priv), 32'h3);
        chk("legal virt", 32'(resume_virt), 32'h0);
        apb(1'h1, `DBGC_OFS_CSR, 32'h00000011);
        chk("super priv", 32'(resume_priv), 32'h1);
        resume;
    endtask
    task t_step_mprv;
        enter(dbgc_req_type'(7'h04));
        // Step is only touched while halted
        apb(1'h1, `DBGC_OFS_CSR, 32'h00000017);
        chk("step_en", 32'(step_en), 32'h1);
        resume;
        chk("step entry", 32'(in_debug), 32'h1);
        apb(1'h0, `DBGC_OFS_CSR, 32'h0);
        chk("step cause", 32'(rd[8:6]), 32'h4);
        hart_mprv <= 1'h1;
        apb(1'h1, `DBGC_OFS_CSR, 32'h00000013);
        repeat (2) @(posedge pclk);
        chk("mprv on", 32'(mprv_effective), 32'h1);
        apb(1'h1, `DBGC_OFS_CSR, 32'h00000003);
        repeat (2) @(posedge pclk);
        chk("mprv off", 32'(mprv_effective), 32'h0);
        chk("step off", 32'(step_en), 32'h0);
        resume;
    endtask
    task t_irq;
        apb(1'h1, `DBGC_OFS_IRQ_STAT, 32'h3);
        apb(1'h1, `DBGC_OFS_IRQ_MASK, 32'h3);
        hart_nmi <= 1'h1;
        repeat (3) @(posedge pclk);
        chk("irq nmi", 32'(irq), 32'h1);
        apb(1'h0, `DBGC_OFS_CSR, 32'h0);
        chk("nmip", 32'(rd[3]), 32'h1);
        apb(1'h1, `DBGC_OFS_IRQ_STAT, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 32'(irq), 32'h0);
        hart_nmi <= 1'h0;
        apb(1'h1, `DBGC_OFS_IRQ_MASK, 32'h0);
        enter(dbgc_req_type'(7'h01));
        chk("irq masked", 32'(irq), 32'h0);
        apb(1'h0, `DBGC_OFS_CSR, 32'h0);
        chk("nmip low", 32'(rd[3]), 32'h0);
        apb(1'h1, `DBGC_OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq entry", 32'(irq), 32'h1);
        apb(1'h1, `DBGC_OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq w1c", 32'(irq), 32'h0);
        resume;
    endtask
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hart_req = '0;
        hart_priv = 2'h3;
        hart_virt = 1'h0;
        hart_mprv = 1'h0;
        hart_nmi = 1'h0;
        kick = 1'h0;
        errors = 0;
        n_tests = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        t_reset;
        t_prio;
        t_modes;
        t_step_mprv;
        t_irq;
        conclude;
    end
    // About 280 cycles are needed; the 4000-cycle limit leaves wide margin
    initial begin
        #100000;
        errors++;
        conclude;
    end
endmodule
